/* File: hw/asx_adc_seq.sv */
// Converter sequencer with the input-only extra port and its digital disable registers
//
// Behaviour
// - Ten-bit results, input chosen from two banks of sixteen channels.
// - Extra port line y feeds analog channel 16 plus y.
// - Analog use needs no setup; path comes straight from the pin.
// - Extra port is input only; data register shows lines 15 to 0.
// - Disable bit at one turns off that line's digital input stage.
// - A disabled line no longer works as a digital input.
// - Writing ones to the set register sets those disable bits.
// - Writing ones to the clear register clears those disable bits.
// - Self-calibration runs after every reset.
// - Sample and conversion durations are set by software.
// - Completing over an unread result raises an overrun request.
// - Alternative protection holds the next conversion until the result is read.
// - Single mode converts the chosen channel once into the main result.
// - Continuous mode converts the chosen channel again and again.
// - Scan mode converts each chosen channel once, storing each result.
// - Continuous scan repeats the channel scan, storing each result.
// - Every stored result raises a request for software or event transfer.
// - Wait-for-read keeps a new result buffered and pauses until read.
// - Continuous modes accept an injected conversion between regular ones.
// - Injected results go to the secondary result register field.
// - After injection the previous continuous mode carries on.
// - Lines not converted remain usable as digital inputs.
// - Busy shows during calibration; no conversion runs meanwhile.
`timescale 1ns/1ps
module asx_adc_seq #(
   parameter int CAL_CYCLES = asx_pkg::ASX_CAL_CYCLES,
   parameter int PORT_W = 16
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire asx_pkg::asx_bus_req_t bus_req,
   output logic [15:0] bus_rdata,
   output logic bus_rvalid,
   input wire logic [PORT_W-1:0] ext_port_pins,
   output logic [PORT_W-1:0] ext_port_schmitt_en,
   input wire logic inj_trigger,
   output logic [4:0] core_channel,
   output logic core_sample,
   output logic core_convert,
   input wire logic [9:0] core_result,
   output logic converter_busy_flag,
   output logic result_req,
   output logic overrun_req,
   output logic inj_done_req
);
   import asx_pkg::*;

   logic [PORT_W-1:0] pin_level;
   logic [PORT_W-1:0] didis_reg, didis_next;
   logic [15:0] time_reg, time_next;
   logic [3:0] ch_reg, ch_next;
   asx_mode_t mode_reg, mode_next;
   logic start_reg, start_next;
   logic wr_reg, wr_next;
   logic inj_pend_reg, inj_pend_next;
   logic [4:0] injch_reg, injch_next;
   logic src_reg, src_next;
   logic [9:0] main_reg, main_next;
   logic [9:0] tmp_reg, tmp_next;
   logic [9:0] sec_reg, sec_next;
   logic res_flag_reg, res_flag_next;
   logic ovr_flag_reg, ovr_flag_next;
   logic inj_flag_reg, inj_flag_next;
   logic unread_reg, unread_next;
   asx_state_t state_reg, state_next;
   logic [ASX_CNT_W-1:0] cnt_reg, cnt_next;
   logic [3:0] scan_reg, scan_next;
   logic injecting_reg, injecting_next;
   logic [4:0] cur_ch_reg, cur_ch_next;
   logic [15:0] rdata_reg, rdata_next;
   logic rvalid_reg;

   logic wr_hit_ctrl, rd_main, conv_done;
   logic [15:0] ctrl_view, port_view;

   asx_pin_filter #(.W(PORT_W)) u_pin_filter (
      .mclk(mclk),
      .rstn(rstn),
      .pins(ext_port_pins),
      .level(pin_level)
   );

   function automatic logic hit(input asx_bus_req_t r, input logic [15:0] a, input logic w);
      return (w ? r.wr : r.rd) && (r.addr == a);
   endfunction

   assign wr_hit_ctrl = hit(bus_req, ASX_ADDR_CTRL, 1'b1);
   assign rd_main = hit(bus_req, ASX_ADDR_MAIN, 1'b0);
   assign conv_done = (state_reg == ASX_S_CONV) && (cnt_reg == '0);
   assign port_view = 16'(pin_level & ~didis_reg);
   assign ctrl_view = {1'b0, injch_reg, inj_pend_reg, wr_reg, converter_busy_flag,
                       start_reg, mode_reg, ch_reg};

   // Disable bits, timing and misc registers
   always_comb begin
      didis_next = didis_reg;
      time_next = time_reg;
      src_next = src_reg;
      if (hit(bus_req, ASX_ADDR_DIDIS, 1'b1)) begin
         didis_next = bus_req.wdata[PORT_W-1:0];
      end
      if (hit(bus_req, ASX_ADDR_DIDIS_SET, 1'b1)) begin
         didis_next = didis_reg | bus_req.wdata[PORT_W-1:0];
      end
      if (hit(bus_req, ASX_ADDR_DIDIS_CLR, 1'b1)) begin
         didis_next = didis_reg & ~bus_req.wdata[PORT_W-1:0];
      end
      if (hit(bus_req, ASX_ADDR_TIME, 1'b1)) begin
         time_next = bus_req.wdata;
      end
      if (hit(bus_req, ASX_ADDR_MISC, 1'b1)) begin
         src_next = bus_req.wdata[ASX_MISC_SRC];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         didis_reg <= PORT_W'(ASX_DIDIS_RST);
         time_reg <= ASX_TIME_RST;
         src_reg <= 1'b0;
      end else begin
         didis_reg <= didis_next;
         time_reg <= time_next;
         src_reg <= src_next;
      end
   end

   // Sequencer, results and flags
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      ch_next = ch_reg;
      mode_next = mode_reg;
      start_next = start_reg;
      wr_next = wr_reg;
      injch_next = injch_reg;
      inj_pend_next = inj_pend_reg;
      main_next = main_reg;
      tmp_next = tmp_reg;
      sec_next = sec_reg;
      res_flag_next = res_flag_reg;
      ovr_flag_next = ovr_flag_reg;
      inj_flag_next = inj_flag_reg;
      unread_next = unread_reg;
      scan_next = scan_reg;
      injecting_next = injecting_reg;
      cur_ch_next = cur_ch_reg;

      if (wr_hit_ctrl) begin
         ch_next = bus_req.wdata[ASX_CTRL_CH_LSB +: 4];
         mode_next = asx_mode_t'(bus_req.wdata[ASX_CTRL_MODE_LSB +: 2]);
         start_next = bus_req.wdata[ASX_CTRL_START];
         wr_next = bus_req.wdata[ASX_CTRL_WR];
         injch_next = bus_req.wdata[ASX_CTRL_INJCH_LSB +: 5];
         if (bus_req.wdata[ASX_CTRL_START] && !start_reg) begin
            scan_next = bus_req.wdata[ASX_CTRL_CH_LSB +: 4];
         end
      end
      if (hit(bus_req, ASX_ADDR_STAT, 1'b1)) begin
         res_flag_next = res_flag_reg & ~bus_req.wdata[ASX_STAT_RES];
         ovr_flag_next = ovr_flag_reg & ~bus_req.wdata[ASX_STAT_OVR];
         inj_flag_next = inj_flag_reg & ~bus_req.wdata[ASX_STAT_INJ];
      end
      if (rd_main) begin
         unread_next = 1'b0;
      end

      unique case (state_reg)
         ASX_S_CAL: begin
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == '0) begin
               // Calibration leaves a spurious result behind
               main_next = ASX_CAL_RESULT;
               unread_next = 1'b1;
               res_flag_next = 1'b1;
               ovr_flag_next = 1'b1;
               state_next = ASX_S_IDLE;
            end
         end
         ASX_S_IDLE: begin
            if (inj_pend_reg && start_reg && asx_is_cont(mode_reg)) begin
               injecting_next = 1'b1;
               inj_pend_next = 1'b0;
               cur_ch_next = injch_reg;
               cnt_next = ASX_CNT_W'(time_reg[ASX_TIME_SMP_LSB +: 8]);
               state_next = ASX_S_SAMPLE;
            end else if (start_reg) begin
               // bank bit picks channels 16 to 31
               injecting_next = 1'b0;
               cur_ch_next = {src_reg, scan_reg};
               cnt_next = ASX_CNT_W'(time_reg[ASX_TIME_SMP_LSB +: 8]);
               state_next = ASX_S_SAMPLE;
            end
         end
         ASX_S_SAMPLE: begin
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == '0) begin
               cnt_next = ASX_CNT_W'(time_reg[ASX_TIME_CNV_LSB +: 8]);
               state_next = ASX_S_CONV;
            end
         end
         ASX_S_CONV: begin
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == '0) begin
               state_next = ASX_S_IDLE;
               if (injecting_reg) begin
                  sec_next = core_result;
                  inj_flag_next = 1'b1;
                  injecting_next = 1'b0;
               end else begin
                  if (unread_reg && !rd_main && wr_reg) begin
                     tmp_next = core_result;
                     state_next = ASX_S_HOLD;
                  end else begin
                     main_next = core_result;
                     unread_next = 1'b1;
                     res_flag_next = 1'b1;
                     if (unread_reg && !rd_main) begin
                        ovr_flag_next = 1'b1;
                     end
                  end
                  // scan walks down to channel 0
                  unique case (mode_reg)
                     ASX_M_SINGLE: start_next = 1'b0;
                     ASX_M_CONT: start_next = start_reg;
                     ASX_M_SCAN, ASX_M_SCAN_CONT: begin
                        if (scan_reg == 4'h0) begin
                           scan_next = ch_reg;
                           if (mode_reg == ASX_M_SCAN) begin
                              start_next = 1'b0;
                           end
                        end else begin
                           scan_next = scan_reg - 1'b1;
                        end
                     end
                  endcase
               end
            end
         end
         ASX_S_HOLD: begin
            // Released by the read that empties the main result
            if (rd_main) begin
               main_next = tmp_reg;
               unread_next = 1'b1;
               res_flag_next = 1'b1;
               state_next = ASX_S_IDLE;
            end
         end
      endcase

      // Trigger beats a same-cycle accept
      if (inj_trigger || (wr_hit_ctrl && bus_req.wdata[ASX_CTRL_INJ])) begin
         inj_pend_next = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ASX_S_CAL;
         cnt_reg <= ASX_CNT_W'(CAL_CYCLES - 1);
         ch_reg <= 4'h0;
         mode_reg <= ASX_M_SINGLE;
         start_reg <= 1'b0;
         wr_reg <= 1'b0;
         injch_reg <= 5'h00;
         inj_pend_reg <= 1'b0;
         main_reg <= 10'h000;
         tmp_reg <= 10'h000;
         sec_reg <= 10'h000;
         res_flag_reg <= 1'b0;
         ovr_flag_reg <= 1'b0;
         inj_flag_reg <= 1'b0;
         unread_reg <= 1'b0;
         scan_reg <= 4'h0;
         injecting_reg <= 1'b0;
         cur_ch_reg <= 5'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ch_reg <= ch_next;
         mode_reg <= mode_next;
         start_reg <= start_next;
         wr_reg <= wr_next;
         injch_reg <= injch_next;
         inj_pend_reg <= inj_pend_next;
         main_reg <= main_next;
         tmp_reg <= tmp_next;
         sec_reg <= sec_next;
         res_flag_reg <= res_flag_next;
         ovr_flag_reg <= ovr_flag_next;
         inj_flag_reg <= inj_flag_next;
         unread_reg <= unread_next;
         scan_reg <= scan_next;
         injecting_reg <= injecting_next;
         cur_ch_reg <= cur_ch_next;
      end
   end

   // Read mux; unmapped and write-only addresses read as zero
   always_comb begin
      rdata_next = 16'h0000;
      unique case (bus_req.addr)
         ASX_ADDR_PORT_DATA: rdata_next = port_view;
         ASX_ADDR_DIDIS: rdata_next = 16'(didis_reg);
         ASX_ADDR_CTRL: rdata_next = ctrl_view;
         ASX_ADDR_MAIN: rdata_next = {6'h00, main_reg};
         ASX_ADDR_SEC: rdata_next = {6'h00, sec_reg};
         ASX_ADDR_STAT: rdata_next = {12'h000, unread_reg, inj_flag_reg, ovr_flag_reg,
                                      res_flag_reg};
         ASX_ADDR_TIME: rdata_next = time_reg;
         ASX_ADDR_MISC: rdata_next = {15'h0000, src_reg};
         default: rdata_next = 16'h0000;
      endcase
      if (!bus_req.rd) begin
         rdata_next = rdata_reg;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 16'h0000;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= bus_req.rd;
      end
   end

   assign bus_rdata = rdata_reg;
   assign bus_rvalid = rvalid_reg;
   // pad stage only follows the disable bits
   assign ext_port_schmitt_en = ~didis_reg;
   assign core_channel = cur_ch_reg;
   assign core_sample = (state_reg == ASX_S_SAMPLE);
   assign core_convert = (state_reg == ASX_S_CONV);
   assign converter_busy_flag = (state_reg != ASX_S_IDLE);
   assign result_req = res_flag_reg;
   assign overrun_req = ovr_flag_reg;
   assign inj_done_req = inj_flag_reg;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence seq_regular_done;
      conv_done && !injecting_reg;
   endsequence
   sequence seq_hold_entry;
      seq_regular_done ##0 (unread_reg && !rd_main && wr_reg);
   endsequence

   a_didis_set_bits: assert property (
      hit(bus_req, ASX_ADDR_DIDIS_SET, 1'b1) |=>
         didis_reg == ($past(didis_reg) | $past(bus_req.wdata[PORT_W-1:0])))
      else $error("set companion did not set the disable bits");
   a_didis_clr_bits: assert property (
      hit(bus_req, ASX_ADDR_DIDIS_CLR, 1'b1) |=>
         didis_reg == ($past(didis_reg) & ~$past(bus_req.wdata[PORT_W-1:0])))
      else $error("clear companion did not clear the disable bits");
   a_port_read_gated: assert property (
      hit(bus_req, ASX_ADDR_PORT_DATA, 1'b0) |=>
         bus_rvalid && ((bus_rdata & 16'($past(didis_reg))) == 16'h0000))
      else $error("disabled line read as digital input");
   a_cal_no_conv: assert property (
      state_reg == ASX_S_CAL |-> converter_busy_flag && !core_sample && !core_convert)
      else $error("conversion activity during calibration");
   a_cal_end_flags: assert property (
      (state_reg == ASX_S_CAL) ##1 (state_reg == ASX_S_IDLE) |->
         result_req && overrun_req)
      else $error("calibration end did not raise both requests");
   a_overrun_raise: assert property (
      seq_regular_done ##0 (unread_reg && !rd_main && !wr_reg) |=>
         overrun_req && main_reg == $past(core_result))
      else $error("overrun not raised on unread result");
   a_wait_hold: assert property (
      seq_hold_entry |=> state_reg == ASX_S_HOLD && main_reg == $past(main_reg)
         && !(overrun_req && !$past(ovr_flag_reg)))
      else $error("wait-for-read did not hold the result");
   a_hold_release: assert property (
      state_reg == ASX_S_HOLD && !rd_main |=> state_reg == ASX_S_HOLD && !core_sample)
      else $error("conversion resumed before the read");
   a_inj_result: assert property (
      conv_done && injecting_reg |=> sec_reg == $past(core_result) && inj_done_req
         && mode_reg == $past(mode_reg) && start_reg == $past(start_reg))
      else $error("injected result misplaced or mode disturbed");
   a_single_stop: assert property (
      seq_regular_done ##0 ((mode_reg == ASX_M_SINGLE) && !wr_hit_ctrl) |=> !start_reg)
      else $error("single conversion did not stop");
endmodule // asx_adc_seq

/* File: hw/asx_pin_filter.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module asx_pin_filter #(
   parameter int W = 16
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [W-1:0] pins,
   output logic [W-1:0] level
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] level_reg;
   logic [W-1:0] level_next;

   always_comb begin
      level_next = level_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            level_next[i] = s3_reg[i];
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         level_reg <= '0;
      end else begin
         s1_reg <= pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= level_next;
      end
   end

   assign level = level_reg;
endmodule // asx_pin_filter

/* File: hw/asx_pkg.sv */
// Shared constants and types of the converter sequencer with the extra analog port
package asx_pkg;
   // Register addresses on the on-chip peripheral bus
   localparam logic [15:0] ASX_ADDR_PORT_DATA = 16'hebd0;
   localparam logic [15:0] ASX_ADDR_DIDIS = 16'hebd2;
   localparam logic [15:0] ASX_ADDR_DIDIS_SET = 16'hebd4;
   localparam logic [15:0] ASX_ADDR_DIDIS_CLR = 16'hebd6;
   localparam logic [15:0] ASX_ADDR_CTRL = 16'hebe0;
   localparam logic [15:0] ASX_ADDR_MAIN = 16'hebe2;
   localparam logic [15:0] ASX_ADDR_SEC = 16'hebe4;
   localparam logic [15:0] ASX_ADDR_STAT = 16'hebe6;
   localparam logic [15:0] ASX_ADDR_TIME = 16'hebe8;
   localparam logic [15:0] ASX_ADDR_MISC = 16'hebea;

   // Control register fields
   localparam int ASX_CTRL_CH_LSB = 0;
   localparam int ASX_CTRL_MODE_LSB = 4;
   localparam int ASX_CTRL_START = 6;
   localparam int ASX_CTRL_BUSY = 7;
   localparam int ASX_CTRL_WR = 8;
   localparam int ASX_CTRL_INJ = 9;
   localparam int ASX_CTRL_INJCH_LSB = 10;

   // Status register fields; result, overrun and injection bits write one to clear, unread clears on a main result read
   localparam int ASX_STAT_RES = 0;
   localparam int ASX_STAT_OVR = 1;
   localparam int ASX_STAT_INJ = 2;
   localparam int ASX_STAT_UNREAD = 3;

   // Timing register fields, counts in clock cycles
   localparam int ASX_TIME_SMP_LSB = 0;
   localparam int ASX_TIME_CNV_LSB = 8;

   // Miscellaneous register: bank select for the analog source
   localparam int ASX_MISC_SRC = 0;

   // Reset values
   localparam logic [15:0] ASX_DIDIS_RST = 16'h0000;
   localparam logic [15:0] ASX_TIME_RST = 16'h1010;
   localparam logic [9:0] ASX_CAL_RESULT = 10'h000;

   // Calibration length in clock cycles
   localparam int ASX_CAL_CYCLES = 40629;
   localparam int ASX_CNT_W = 16;

   typedef enum logic [1:0] {
      ASX_M_SINGLE,
      ASX_M_CONT,
      ASX_M_SCAN,
      ASX_M_SCAN_CONT
   } asx_mode_t;

   typedef enum logic [2:0] {
      ASX_S_CAL,
      ASX_S_IDLE,
      ASX_S_SAMPLE,
      ASX_S_CONV,
      ASX_S_HOLD
   } asx_state_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } asx_bus_req_t;

   function automatic logic asx_is_cont(input asx_mode_t m);
      return (m == ASX_M_CONT) || (m == ASX_M_SCAN_CONT);
   endfunction
endpackage

/* File: verification/asx_adc_seq_bench.sv */
// Self-checking bench for the converter sequencer and the extra port registers
`timescale 1ns/1ps
module asx_adc_seq_bench;
   import asx_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   asx_bus_req_t bus_req = '0;
   logic [15:0] bus_rdata, schmitt;
   logic [15:0] pins = 16'h0000;
   logic inj_trigger = 1'b0;
   logic bus_rvalid, core_sample, core_convert, busy, res, ovr, inj;
   logic [4:0] core_channel;
   logic [9:0] core_result;
   logic [3:0] fl;
   int n_fail = 0;
   int checks_done = 0;
   string q_name[$];
   logic [15:0] q_exp[$];
   assign fl = {busy, inj, ovr, res};
   always #2.5 mclk = ~mclk;
   // Short calibration keeps the run brief
   asx_adc_seq #(.CAL_CYCLES(20)) dut (.mclk(mclk), .rstn(rstn), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ext_port_pins(pins),
      .ext_port_schmitt_en(schmitt), .inj_trigger(inj_trigger), .core_channel(core_channel),
      .core_sample(core_sample), .core_convert(core_convert), .core_result(core_result),
      .converter_busy_flag(busy), .result_req(res), .overrun_req(ovr), .inj_done_req(inj));
   asx_core_model model (.mclk(mclk), .core_channel(core_channel),
      .core_convert(core_convert), .core_result(core_result));
   function automatic logic [15:0] expv(input logic [4:0] c);
      return {6'h00, c, ~c};
   endfunction
   function automatic logic [15:0] ctl(input logic [3:0] ch, input logic [1:0] md, input logic w);
      return {1'b0, 5'h1a, 1'b0, w, 1'b0, 1'b1, md, ch};
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk);
      #1 bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge mclk);
      #1 bus_req.wr = 1'b0;
   endtask
   task automatic rd(input string what, input logic [15:0] a, input logic [15:0] exp);
      q_name.push_back(what);
      q_exp.push_back(exp);
      @(posedge mclk);
      #1 bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
      @(posedge mclk);
      #1 bus_req.rd = 1'b0;
   endtask
   // Bounded wait so a stuck flag shows as a mismatch, not a hang
   task automatic wait_for(input string what, input int sel, input logic lvl);
      for (int i = 0; i < 2000 && fl[sel] !== lvl; i++) begin
         @(posedge mclk);
         #1;
      end
      chk(what, 16'(fl[sel]), 16'(lvl));
   endtask
   task automatic done_t(input string t);
      $display("test %s finished, checks %0d, mismatches %0d", t, checks_done, n_fail);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(negedge mclk) begin
      if (bus_rvalid === 1'b1 && q_exp.size() > 0) begin
         chk(q_name.pop_front(), bus_rdata, q_exp.pop_front());
      end
   end
   // Length of the last sampling phase in cycles
   int smp_len = 0;
   int smp_last = 0;
   always @(negedge mclk) begin
      if (core_sample === 1'b1) begin
         smp_len <= smp_len + 1;
      end else if (smp_len != 0) begin
         smp_last <= smp_len;
         smp_len <= 0;
      end
   end
   initial begin
      #100us;
      n_fail++;
      $display("MISMATCH watchdog expected finish seen hang");
      close_out();
   end
   initial begin
      logic [15:0] r, m;
      void'($urandom(51961));
      repeat (8) @(posedge mclk);
      #1 rstn = 1'b1;
      chk("busy in calibration", 16'(busy), 16'h0001);
      rd("disable reset", ASX_ADDR_DIDIS, ASX_DIDIS_RST);
      chk("stages on", schmitt, 16'hffff);
      r = 16'($urandom());
      m = 16'($urandom());
      pins = 16'($urandom());
      wr(ASX_ADDR_DIDIS_SET, r);
      rd("after set", ASX_ADDR_DIDIS, r);
      chk("stages after set", schmitt, ~r);
      wr(ASX_ADDR_DIDIS_CLR, m);
      rd("after clear", ASX_ADDR_DIDIS, r & ~m);
      wr(ASX_ADDR_PORT_DATA, 16'hffff);
      rd("port data", ASX_ADDR_PORT_DATA, pins & ~(r & ~m));
      rd("set reads zero", ASX_ADDR_DIDIS_SET, 16'h0000);
      rd("unmapped", 16'hebfe, 16'h0000);
      done_t("port");
      wait_for("calibration over", 3, 1'b0);
      chk("result after cal", 16'(res), 16'h0001);
      chk("overrun after cal", 16'(ovr), 16'h0001);
      rd("dummy read", ASX_ADDR_MAIN, 16'(ASX_CAL_RESULT));
      wr(ASX_ADDR_STAT, 16'h0007);
      wr(ASX_ADDR_TIME, 16'h2828);
      wr(ASX_ADDR_DIDIS, 16'hffff);
      wr(ASX_ADDR_MISC, 16'h0001);
      wr(ASX_ADDR_CTRL, ctl(4'h3, 2'd0, 1'b0));
      wait_for("single done", 0, 1'b1);
      chk("sample cycles", 16'(smp_last), 16'h0029);
      rd("bank two channel", ASX_ADDR_MAIN, expv(5'd19));
      wr(ASX_ADDR_MISC, 16'h0000);
      wr(ASX_ADDR_STAT, 16'h0001);
      wr(ASX_ADDR_CTRL, ctl(4'h2, 2'd2, 1'b0));
      for (int k = 2; k >= 0; k--) begin
         wait_for("scan step", 0, 1'b1);
         rd("scan result", ASX_ADDR_MAIN, expv(5'(k)));
         wr(ASX_ADDR_STAT, 16'h0001);
      end
      repeat (300) @(posedge mclk);
      chk("scan stopped", 16'(res), 16'h0000);
      wr(ASX_ADDR_CTRL, ctl(4'h1, 2'd3, 1'b0));
      for (int k = 3; k > 0; k--) begin
         wait_for("scan cont step", 0, 1'b1);
         rd("scan cont result", ASX_ADDR_MAIN, expv(5'(k[0])));
         wr(ASX_ADDR_STAT, 16'h0001);
      end
      wr(ASX_ADDR_CTRL, 16'h0000);
      wait_for("scan cont idle", 3, 1'b0);
      rd("scan cont last", ASX_ADDR_MAIN, expv(5'd0));
      wr(ASX_ADDR_STAT, 16'h0007);
      done_t("single and scan");
      wr(ASX_ADDR_CTRL, ctl(4'h1, 2'd1, 1'b0));
      wait_for("first cont result", 0, 1'b1);
      chk("no overrun yet", 16'(ovr), 16'h0000);
      wait_for("overrun raised", 1, 1'b1);
      wr(ASX_ADDR_CTRL, 16'h0000);
      wait_for("idle", 3, 1'b0);
      rd("cont result", ASX_ADDR_MAIN, expv(5'd1));
      wr(ASX_ADDR_STAT, 16'h0007);
      wr(ASX_ADDR_CTRL, ctl(4'h4, 2'd1, 1'b1));
      wait_for("first held result", 0, 1'b1);
      repeat (300) @(posedge mclk);
      chk("no overrun held", 16'(ovr), 16'h0000);
      chk("held busy", 16'(busy), 16'h0001);
      chk("no sampling held", 16'(core_sample), 16'h0000);
      rd("held read", ASX_ADDR_MAIN, expv(5'd4));
      wr(ASX_ADDR_CTRL, 16'h0000);
      rd("buffer read", ASX_ADDR_MAIN, expv(5'd4));
      wait_for("idle again", 3, 1'b0);
      wr(ASX_ADDR_STAT, 16'h0007);
      done_t("overrun");
      wr(ASX_ADDR_CTRL, ctl(4'h0, 2'd1, 1'b0));
      @(posedge mclk);
      #1 inj_trigger = 1'b1;
      @(posedge mclk);
      #1 inj_trigger = 1'b0;
      wait_for("inject done", 2, 1'b1);
      rd("injected", ASX_ADDR_SEC, expv(5'h1a));
      wr(ASX_ADDR_STAT, 16'h0007);
      wait_for("mode resumed", 0, 1'b1);
      rd("after inject", ASX_ADDR_MAIN, expv(5'd0));
      wr(ASX_ADDR_CTRL, 16'h0000);
      wait_for("stopped", 3, 1'b0);
      done_t("inject");
      @(posedge mclk);
      #1 rstn = 1'b0;
      repeat (3) @(posedge mclk);
      #1 rstn = 1'b1;
      chk("busy after reset", 16'(busy), 16'h0001);
      rd("disable cleared", ASX_ADDR_DIDIS, 16'h0000);
      wait_for("recalibrated", 3, 1'b0);
      chk("cal result flag", 16'(res), 16'h0001);
      repeat (4) @(posedge mclk);
      chk("reads answered", 16'(q_exp.size()), 16'h0000);
      done_t("second reset");
      close_out();
   end
endmodule // asx_adc_seq_bench

/* File: verification/asx_core_model.sv */
// Analog front end stand-in returning a channel-coded sample
`timescale 1ns/1ps
module asx_core_model (
   input wire logic mclk,
   input wire logic [4:0] core_channel,
   input wire logic core_convert,
   output logic [9:0] core_result
);
   // Outside conversion the value is junk that changes every cycle
   logic [9:0] junk_reg = 10'h155;
   always_ff @(posedge mclk) begin
      junk_reg <= ~junk_reg;
   end
   assign core_result = core_convert ? {core_channel, ~core_channel} : junk_reg;
endmodule // asx_core_model
